// *** src/epc_defs.vh ***
// Constants for the energy to pulse converter block
// ====================================================
`ifndef EPC_DEFS_VH
`define EPC_DEFS_VH

// ====================================================
// Field positions
`define EPC_PICK_LSB 0
`define EPC_KIND_LSB 0
`define EPC_DIS_LSB 9
`define EPC_LATCH_LSB 12
`define EPC_STROBE_SEL_BIT 2
`define EPC_FIELD_W 3

// ====================================================
// Reset values
`define EPC_COMPUTE_RESET 9'h1ff
`define EPC_PULSE_MODE_RESET 15'h0ea0
`define EPC_DIVIDER_RESET 16'h0000
`define EPC_CONFIG_RESET 1'b0

// ====================================================
// Power kind codes
`define EPC_KIND_ACTIVE 3'h0
`define EPC_KIND_APPARENT 3'h2
`define EPC_KIND_FUND_ACTIVE 3'h3
`define EPC_KIND_FUND_REACTIVE 3'h4

// ====================================================
// Timing
`define EPC_CLOCK_KHZ 50000
`define EPC_CLOCK_PERIOD_NS 20
`define EPC_LOW_HOLD_MS 80
`define EPC_LONG_PERIOD_MS 160
`define EPC_MIN_LOW_NS 1000

`endif

// *** src/epc_energy_pulse.v ***
// Three energy to frequency converters with pin sharing and status
`include "epc_defs.vh"
`default_nettype none

module epc_energy_pulse #(
	parameter PW = 24, // Phase power width
	parameter AW = 32, // First stage accumulator width
	parameter CW = 23, // Pulse timer width
	// Fixed low time for slow pulse trains
	parameter [CW-1:0] LOW_HOLD_CYCLES = `EPC_LOW_HOLD_MS * `EPC_CLOCK_KHZ,
	// Period above which the fixed low time applies
	parameter [CW-1:0] LONG_PERIOD_CYCLES = `EPC_LONG_PERIOD_MS * `EPC_CLOCK_KHZ
) (
	input wire clock,
	input wire rst,
	// Register writes
	input wire [15:0] write_data,
	input wire write_compute_mode,
	input wire write_pulse_mode,
	input wire [2:0] write_divider,
	input wire write_config,
	// Status clear, write one to clear
	input wire [2:0] status_clear,
	input wire [2:0] interrupt_mask_zero,
	// Phase powers, {C, B, A}
	input wire [3*PW-1:0] power_total_active,
	input wire [3*PW-1:0] power_apparent,
	input wire [3*PW-1:0] power_fund_active,
	input wire [3*PW-1:0] power_fund_reactive,
	input wire dsp_update_tick,
	input wire [AW-2:0] stage_threshold,
	// Shared pin sources
	input wire harmonic_update_strobe,
	input wire fast_capture_port,
	input wire fast_capture_clock,
	// Pins
	output reg pulse_out_one,
	output reg pulse_out_two,
	output reg pulse_out_three,
	output reg [2:0] event_status_zero,
	output reg interrupt_line_zero_n,
	// Accumulator latch strobes per kind
	output reg latch_total_active,
	output reg latch_apparent,
	output reg latch_fund_active,
	output reg latch_fund_reactive
);

	// Minimum low time, rounded up to whole cycles
	localparam [CW-1:0] MIN_LOW_CYCLES =
		(`EPC_MIN_LOW_NS + `EPC_CLOCK_PERIOD_NS - 1) / `EPC_CLOCK_PERIOD_NS;

	// ====================================================
	// Configuration registers
	reg [8:0] compute_mode_register; // Phase picks
	reg [14:0] pulse_mode_register; // Kinds, disables, latches
	reg [47:0] pulse_divider; // Three dividers
	reg second_pin_strobe_select; // Pin two source

	// Register writes
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			compute_mode_register <= `EPC_COMPUTE_RESET;
			pulse_mode_register <= `EPC_PULSE_MODE_RESET;
			pulse_divider <= {3{`EPC_DIVIDER_RESET}};
			second_pin_strobe_select <= `EPC_CONFIG_RESET;
		end else begin
			if (write_compute_mode) begin
				compute_mode_register <= write_data[8:0];
			end
			if (write_pulse_mode) begin
				pulse_mode_register <= write_data[14:0];
			end
			if (write_divider[0]) begin
				pulse_divider[15:0] <= write_data;
			end
			if (write_divider[1]) begin
				pulse_divider[31:16] <= write_data;
			end
			if (write_divider[2]) begin
				pulse_divider[47:32] <= write_data;
			end
			if (write_config) begin
				second_pin_strobe_select <= write_data[`EPC_STROBE_SEL_BIT];
			end
		end
	end

	// ====================================================
	// Converters
	wire [2:0] conv_level; // Raw converter outputs
	wire [2:0] fall_evt; // Converter falling edges
	wire [11:0] latch_hit; // Kind hits per converter

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : conv
			// Per converter fields
			wire [2:0] pick = compute_mode_register[`EPC_PICK_LSB+3*gi +: `EPC_FIELD_W];
			wire [2:0] kind = pulse_mode_register[`EPC_KIND_LSB+3*gi +: `EPC_FIELD_W];
			wire latch_en = pulse_mode_register[`EPC_LATCH_LSB+gi];
			wire [15:0] div = pulse_divider[16*gi +: 16];
			// Zero divider counts as one
			wire [15:0] n_eff = (div == 16'h0000) ? 16'h0001 : div;
			// Low span in first stage pulses, half the divider rounded up
			wire [15:0] half = {1'b0, n_eff[15:1]} + {15'h0000, n_eff[0]};
			reg [3*PW-1:0] sel_bus; // Chosen power kind
			reg [3:0] kind_hot; // One-hot of kind
			wire signed [PW+1:0] pa;
			wire signed [PW+1:0] pb;
			wire signed [PW+1:0] pc;
			wire signed [PW+1:0] psum;
			wire signed [AW-1:0] next_acc;
			wire signed [AW-1:0] thr;
			reg signed [AW-1:0] acc; // First stage energy
			reg stage_pulse; // First stage output
			reg [15:0] div_cnt; // Second stage count
			reg level; // Converter output
			reg [CW-1:0] hold_cnt; // Cycles since fall
			reg long_mode; // Last period was long
			reg fall; // Falling edge pulse

			// Kind decode, reserved codes feed nothing
			always @* begin
				sel_bus = {3*PW{1'b0}};
				kind_hot = 4'h0;
				case (kind)
					`EPC_KIND_ACTIVE: begin
						sel_bus = power_total_active;
						kind_hot = 4'h1;
					end
					`EPC_KIND_APPARENT: begin
						sel_bus = power_apparent;
						kind_hot = 4'h2;
					end
					`EPC_KIND_FUND_ACTIVE: begin
						sel_bus = power_fund_active;
						kind_hot = 4'h4;
					end
					`EPC_KIND_FUND_REACTIVE: begin
						sel_bus = power_fund_reactive;
						kind_hot = 4'h8;
					end
					default: begin
						sel_bus = {3*PW{1'b0}};
						kind_hot = 4'h0;
					end
				endcase
			end

			// Sum of picked phases
			assign pa = pick[0] ? {{2{sel_bus[PW-1]}}, sel_bus[PW-1:0]} : {PW+2{1'b0}};
			assign pb = pick[1] ? {{2{sel_bus[2*PW-1]}}, sel_bus[2*PW-1:PW]} : {PW+2{1'b0}};
			assign pc = pick[2] ? {{2{sel_bus[3*PW-1]}}, sel_bus[3*PW-1:2*PW]} : {PW+2{1'b0}};
			assign psum = pa + pb + pc;
			assign next_acc = acc + {{AW-PW-2{psum[PW+1]}}, psum};
			assign thr = {1'b0, stage_threshold};

			// First stage: threshold accumulation per DSP tick
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					acc <= {AW{1'b0}};
					stage_pulse <= 1'b0;
				end else begin
					stage_pulse <= 1'b0;
					if (pick == 3'h0 || thr == {AW{1'b0}}) begin
						// Nothing picked, nothing emitted
						acc <= {AW{1'b0}};
					end else if (dsp_update_tick) begin
						if (next_acc >= thr) begin
							acc <= next_acc - thr;
							stage_pulse <= 1'b1;
						end else if (next_acc <= -thr) begin
							// Negative energy also yields pulses
							acc <= next_acc + thr;
							stage_pulse <= 1'b1;
						end else begin
							acc <= next_acc;
						end
					end
				end
			end

			// Second stage: divide and shape the pulse
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					div_cnt <= 16'h0000;
					level <= 1'b1;
					hold_cnt <= {CW{1'b0}};
					long_mode <= 1'b1;
					fall <= 1'b0;
				end else begin
					fall <= 1'b0;
					// Period timer saturates at the long limit
					if (hold_cnt < LONG_PERIOD_CYCLES) begin
						hold_cnt <= hold_cnt + {{CW-1{1'b0}}, 1'b1};
					end
					if (stage_pulse && div_cnt >= n_eff - 16'h0001) begin
						// Divider wrap starts a new pulse
						div_cnt <= 16'h0000;
						level <= 1'b0;
						fall <= level;
						hold_cnt <= {CW{1'b0}};
						long_mode <= (hold_cnt >= LONG_PERIOD_CYCLES);
					end else begin
						if (stage_pulse) begin
							div_cnt <= div_cnt + 16'h0001;
						end
						if (!level) begin
							if (long_mode) begin
								if (hold_cnt >= LOW_HOLD_CYCLES - {{CW-1{1'b0}}, 1'b1}) begin
									level <= 1'b1;
								end
							end else if (n_eff == 16'h0001) begin
								// Divider one leaves only a short strobe
								if (hold_cnt >= MIN_LOW_CYCLES - {{CW-1{1'b0}}, 1'b1}) begin
									level <= 1'b1;
								end
							end else if (stage_pulse && div_cnt + 16'h0001 >= half) begin
								level <= 1'b1;
							end
						end
					end
				end
			end

			assign conv_level[gi] = level;
			assign fall_evt[gi] = fall;
			// Latch only the selected kind when enabled
			assign latch_hit[4*gi +: 4] = (fall && latch_en) ? kind_hot : 4'h0;
		end
	endgenerate

	// ====================================================
	// Pins, status and latch strobes

	// Disabled pin holds high; shared functions override
	wire [2:0] pin_dis = pulse_mode_register[`EPC_DIS_LSB +: `EPC_FIELD_W];
	wire [3:0] latch_any = latch_hit[3:0] | latch_hit[7:4] | latch_hit[11:8];
	// Set wins over a clear in the same cycle
	wire [2:0] next_status = (event_status_zero & ~status_clear) | fall_evt;

	// Output registers
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pulse_out_one <= 1'b1;
			pulse_out_two <= 1'b1;
			pulse_out_three <= 1'b1;
			event_status_zero <= 3'h0;
			interrupt_line_zero_n <= 1'b1;
			latch_total_active <= 1'b0;
			latch_apparent <= 1'b0;
			latch_fund_active <= 1'b0;
			latch_fund_reactive <= 1'b0;
		end else begin
			pulse_out_one <= conv_level[0] | pin_dis[0];
			if (second_pin_strobe_select) begin
				pulse_out_two <= harmonic_update_strobe;
			end else begin
				pulse_out_two <= conv_level[1] | pin_dis[1];
			end
			if (fast_capture_port) begin
				pulse_out_three <= fast_capture_clock;
			end else begin
				pulse_out_three <= conv_level[2] | pin_dis[2];
			end
			// Events count even when the pin is disabled
			event_status_zero <= next_status;
			interrupt_line_zero_n <= ~|(next_status & interrupt_mask_zero);
			latch_total_active <= latch_any[0];
			latch_apparent <= latch_any[1];
			latch_fund_active <= latch_any[2];
			latch_fund_reactive <= latch_any[3];
		end
	end

endmodule

`default_nettype wire

// *** verification/epc_monitor.sv ***
// Checker on the pins of the energy to pulse converter
`default_nettype none
module epc_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] status_clear,
	input wire logic [2:0] interrupt_mask_zero,
	input wire logic fast_capture_port,
	input wire logic fast_capture_clock,
	input wire logic pulse_out_one,
	input wire logic pulse_out_three,
	input wire logic [2:0] event_status_zero,
	input wire logic interrupt_line_zero_n,
	input wire logic latch_total_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// ====================================
	// Pin one events, interrupt line, pin three capture, latch strobe and reset
	sequence s_fall;
		$fell(pulse_out_one);
	endsequence
	// Clear taken with no fall on the next edge
	sequence s_quiet;
		status_clear[0] && pulse_out_one ##1 pulse_out_one;
	endsequence
	property p_fall_flag;
		s_fall |-> event_status_zero[0];
	endproperty
	property p_sticky;
		event_status_zero[0] && !status_clear[0] |=> event_status_zero[0];
	endproperty
	property p_clear;
		s_quiet |-> !event_status_zero[0];
	endproperty
	// Stable masked flag must hold the line low
	property p_irq_on;
		(|(event_status_zero & interrupt_mask_zero)) && $stable(event_status_zero)
			&& $stable(interrupt_mask_zero) |-> !interrupt_line_zero_n;
	endproperty
	property p_irq_off;
		event_status_zero == 3'h0 && $stable(event_status_zero) |-> interrupt_line_zero_n;
	endproperty
	property p_capture;
		fast_capture_port && $past(fast_capture_port) |-> pulse_out_three == $past(fast_capture_clock);
	endproperty
	property p_latch;
		latch_total_active |=> !latch_total_active;
	endproperty
	property p_reset;
		$fell(rst) |-> pulse_out_one && pulse_out_three && event_status_zero == 3'h0;
	endproperty
	a_fall_flag: assert property (p_fall_flag) else $error("fall without flag");
	a_sticky: assert property (p_sticky) else $error("flag lost");
	a_clear: assert property (p_clear) else $error("flag not cleared");
	a_irq_on: assert property (p_irq_on) else $error("line not low");
	a_irq_off: assert property (p_irq_off) else $error("line low");
	a_capture: assert property (p_capture) else $error("pin three not capture clock");
	a_latch: assert property (p_latch) else $error("latch too long");
	a_reset: assert property (p_reset) else $error("bad reset state");
endmodule
bind epc_energy_pulse epc_monitor u_mon (.clock(clock), .rst(rst), .status_clear(status_clear),
	.interrupt_mask_zero(interrupt_mask_zero), .fast_capture_port(fast_capture_port),
	.fast_capture_clock(fast_capture_clock), .pulse_out_one(pulse_out_one), .pulse_out_three(pulse_out_three),
	.event_status_zero(event_status_zero), .interrupt_line_zero_n(interrupt_line_zero_n),
	.latch_total_active(latch_total_active));
`default_nettype wire

// *** verification/epc_cal_receiver.sv ***
// Calibration receiver model timing active-low pulses on one pin
`default_nettype none
module epc_cal_receiver (
	input wire logic clock,
	input wire logic pulse_n,
	output var int falls,
	output var int low_width
);
	timeunit 1ns;
	timeprecision 1ns;
	int low_count = 0; // Cycles low so far
	initial falls = 0;
	initial low_width = 0;
	// ====================================
	// Count falls and time each low phase
	always @(posedge clock) begin
		if (!pulse_n) low_count <= low_count + 1;
		if (!pulse_n && low_count == 0) falls <= falls + 1;
		if (pulse_n && low_count != 0) begin
			low_width <= low_count;
			low_count <= 0;
		end
	end
endmodule
`default_nettype wire

// *** verification/tb_epc_energy_pulse.sv ***
// Self-checking bench for the energy to pulse converter
`default_nettype none
module tb_epc_energy_pulse;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [23:0] P = 24'h0003e8; // One threshold of power per phase
	logic clock = 1'b0, rst = 1'b1, write_compute_mode = 1'b0, write_pulse_mode = 1'b0, write_config = 1'b0;
	logic dsp_update_tick = 1'b0, harmonic_update_strobe = 1'b0, fast_capture_port = 1'b0, fast_capture_clock = 1'b0;
	logic [15:0] write_data = 16'h0000;
	logic [2:0] write_divider = 3'h0, status_clear = 3'h0, interrupt_mask_zero = 3'h7, event_status_zero;
	logic [71:0] power_total_active = 72'h0, power_apparent = 72'h0, power_fund_active = 72'h0;
	logic [71:0] power_fund_reactive = 72'h0;
	logic [30:0] stage_threshold = 31'h3e8;
	logic pulse_out_one, pulse_out_two, pulse_out_three, interrupt_line_zero_n;
	logic latch_total_active, latch_apparent, latch_fund_active, latch_fund_reactive;
	int err_count = 0, samples_checked = 0, cycles = 0, latches = 0, n1, n2, n3, w1, w2, w3, f1, f2, f3, l1;
	int latch_other = 0; // Latch strobes of kinds that no converter latches
	int seed = 32'h57ba7d87;
	epc_energy_pulse #(.LOW_HOLD_CYCLES(23'h0000c8), .LONG_PERIOD_CYCLES(23'h000190)) dut (.clock, .rst,
		.write_data, .write_compute_mode, .write_pulse_mode, .write_divider, .write_config, .status_clear,
		.interrupt_mask_zero, .power_total_active, .power_apparent, .power_fund_active, .power_fund_reactive,
		.dsp_update_tick, .stage_threshold, .harmonic_update_strobe, .fast_capture_port, .fast_capture_clock,
		.pulse_out_one, .pulse_out_two, .pulse_out_three, .event_status_zero, .interrupt_line_zero_n,
		.latch_total_active, .latch_apparent, .latch_fund_active, .latch_fund_reactive);
	epc_cal_receiver rx1 (.clock, .pulse_n(pulse_out_one), .falls(n1), .low_width(w1));
	epc_cal_receiver rx2 (.clock, .pulse_n(pulse_out_two), .falls(n2), .low_width(w2));
	epc_cal_receiver rx3 (.clock, .pulse_n(pulse_out_three), .falls(n3), .low_width(w3));
	// ====================================
	// Clock, cycle ceiling and latch counter
	initial forever #10 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (latch_total_active === 1'b1) latches <= latches + 1;
		if ((latch_apparent | latch_fund_active | latch_fund_reactive) !== 1'b0) latch_other <= latch_other + 1;
		if (cycles == 12000) begin
			err_count++;
			print_verdict();
		end
	end
	// Model: one stage pulse per tick, one fall per divider count
	function automatic int exp_falls(input int k, input int n);
		return (k + n - 1) / n;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		#1;
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %0d expected %0d", $time, seen, exp);
		end
	endtask
	// Write strobes as {config, divider[2:0], pulse mode, compute mode}
	task automatic wr(input logic [5:0] sel, input logic [15:0] d);
		@(posedge clock);
		write_data <= d;
		{write_config, write_divider, write_pulse_mode, write_compute_mode} <= sel;
		@(posedge clock);
		{write_config, write_divider, write_pulse_mode, write_compute_mode} <= 6'h00;
	endtask
	task automatic ticks(input int n, input int gap);
		repeat (n) begin
			@(posedge clock);
			dsp_update_tick <= 1'b1;
			@(posedge clock);
			dsp_update_tick <= 1'b0;
			repeat (gap - 2) @(posedge clock);
		end
	endtask
	task automatic clr;
		@(posedge clock);
		status_clear <= 3'h7;
		@(posedge clock);
		status_clear <= 3'h0;
	endtask
	task automatic print_verdict;
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ====================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		// Reset kinds: total active, fund reactive and apparent each flag only their own converter, pins held high
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			// Phase A only: one threshold per tick, so no energy is left over for later runs
			power_total_active <= (i == 0) ? {48'h0, P} : 72'h0;
			power_fund_reactive <= (i == 1) ? {48'h0, P} : 72'h0;
			power_apparent <= (i == 2) ? {48'h0, P} : 72'h0;
			clr();
			ticks(4, 6);
			chk(event_status_zero, 32'h1 << i);
			chk({pulse_out_one, pulse_out_two, pulse_out_three}, 3'h7);
		end
		wr(6'h01, 16'h0101);
		wr(6'h02, 16'h1000);
		wr(6'h04, 16'h0004);
		wr(6'h10, 16'h0005);
		power_total_active <= {P, -P, P}; // Phase B cancels A if wrongly picked
		power_fund_reactive <= 72'h0;
		ticks(40, 4);
		clr();
		{f1, f2, f3, l1} = {n1, n2, n3, latches};
		ticks(40, 4);
		repeat (30) @(posedge clock);
		chk(n1 - f1, exp_falls(40, 4));
		chk(n3 - f3, exp_falls(40, 5));
		chk(n2 - f2, 0);
		chk(event_status_zero, 3'h5);
		chk(latches - l1, exp_falls(40, 4));
		chk(w1, 4 / 2 * 4);
		chk(w3, (5 + 1) / 2 * 4);
		wr(6'h10, 16'h0000);
		// Let the low left over from the last run end before counting
		repeat (60) @(posedge clock);
		f3 = n3;
		ticks(12, 150);
		repeat (60) @(posedge clock);
		chk(w1, 200);
		chk(w3, 50);
		chk(n3 - f3, 12);
		wr(6'h20, 16'h0004);
		repeat (8) begin
			@(posedge clock);
			harmonic_update_strobe <= 1'($random(seed));
			fast_capture_clock <= 1'($random(seed));
			fast_capture_port <= 1'b1;
			repeat (2) @(posedge clock);
			chk(pulse_out_two, harmonic_update_strobe);
			chk(pulse_out_three, fast_capture_clock);
		end
		chk(latch_other, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
